/* twcrp_pkg.sv */
// Purpose: Shared constants and types for the two-wire control register port
// Assumes: One 100 MHz system clock at each end
// Notes: Register indices are byte pointers on the serial link
package twcrp_pkg;
	localparam logic [4:0] TWCRP_ADDR_FIXED = 5'h13;
	localparam logic [7:0] TWCRP_REG_TOP = 8'h1D;
	localparam logic [7:0] TWCRP_REG_SYNC_POL = 8'h15;
	localparam logic [7:0] TWCRP_REG_SLICER = 8'h16;
	localparam logic [7:0] TWCRP_REG_HOLD_BEFORE = 8'h17;
	localparam logic [7:0] TWCRP_REG_HOLD_AFTER = 8'h18;
	localparam logic [7:0] TWCRP_REG_TEST_A = 8'h19;
	localparam logic [7:0] TWCRP_REG_TEST_B = 8'h1A;
	localparam logic [7:0] TWCRP_REG_TEST_C = 8'h1B;
	localparam logic [7:0] TWCRP_REG_FORMAT = 8'h1C;
	localparam int TWCRP_SLICER_LSB = 3;
	localparam logic [4:0] TWCRP_SLICER_RESET = 5'h17;
	localparam logic [7:0] TWCRP_HOLD_RESET = 8'h00;
	localparam logic [7:0] TWCRP_TEST_A_RESET = 8'h00;
	localparam logic [7:0] TWCRP_TEST_B_RESET = 8'h00;
	localparam logic [7:0] TWCRP_TEST_C_RESET = 8'h00;
	localparam logic [7:0] TWCRP_FORMAT_RESET = 8'h01;
	localparam int TWCRP_FMT_444_BIT = 0;
	localparam int TWCRP_FMT_SAMPLE_BIT = 1;
	localparam int TWCRP_FMT_RED_FIRST_BIT = 2;
	localparam int TWCRP_STAT_VPOL_BIT = 6;
	localparam int TWCRP_STAT_HOLD_POL_BIT = 5;
	localparam int TWCRP_STAT_HPOL_BIT = 7;
	localparam int TWCRP_CLK_HZ = 100000000;
	localparam int TWCRP_SCL_HZ = 100000;
	localparam int TWCRP_QUARTER_CYC = TWCRP_CLK_HZ / (4 * TWCRP_SCL_HZ);
	localparam int TWCRP_FILTER_LEN = 3;
	typedef enum logic [1:0] {TWCRP_OP_WRITE, TWCRP_OP_READ, TWCRP_OP_SETPTR} twcrp_op_t;
endpackage

/* twcrp_link_if.sv */
// Purpose: Two-wire link between master and slave ends
// Assumes: Open-drain lines with pull-ups, output enable low drives the line low
// Notes: Data level resolved here from both enables, clock level from the master's enable alone
interface twcrp_link_if;
	logic m_scl_oen;
	logic m_sda_oen;
	logic s_sda_oen;
	logic scl;
	logic sda;
	assign scl = m_scl_oen;
	assign sda = m_sda_oen & s_sda_oen;
	modport master (output m_scl_oen, output m_sda_oen, input scl, input sda);
	modport slave (output s_sda_oen, input scl, input sda);
endinterface

/* twcrp_slave.sv */
// Purpose: Two-wire slave port holding the sync and format control registers
// Assumes: Link lines are asynchronous and pass two flip-flops first
// Notes: The slave never stretches the clock
// Summary of operation
// - Slave only; address 10011 plus select pins
// - Eighth bit one reads, zero writes
// - Acknowledge on ninth pulse when address matches
// - Falling data with clock high starts
// - Rising data with clock high stops, idle
// - Data changes only while clock low
// - Every byte shifted most significant first
// - First written byte is register pointer
// - Pointer advances per byte, saturates at top
// - No acknowledge for pointer above top
// - Reads start at pointer, advance per byte
// - Master no-acknowledge ends read, data released
// - Declined write keeps data line released
// - Repeated start accepted without stop
// - Vertical polarity status: zero low, one high
// - Status bit five reports hold-over polarity
// - Slicer threshold code in bits 7:3
// - Edges masked before vertical sync, reset zero
// - Edges masked after vertical sync, reset zero
// - Format bit two selects red chroma first
// - Format bit zero selects 4:4:4 or 4:2:2
// - Host keeps format bit one at zero
module twcrp_slave (
	input wire logic i_clock,
	input wire logic i_rstn,
	twcrp_link_if.slave link,
	input wire logic [1:0] i_bus_addr_select_pins,
	input wire logic i_hsync_pol,
	input wire logic i_vsync_pol,
	input wire logic i_hold_pol,
	output logic [4:0] o_slicer_code,
	output logic [7:0] o_hold_before,
	output logic [7:0] o_hold_after,
	output logic [7:0] o_test_a,
	output logic [7:0] o_test_b,
	output logic [7:0] o_test_c,
	output logic o_full_444,
	output logic o_sample_mode,
	output logic o_chroma_pair_red_first
);
	import twcrp_pkg::*;

	typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK, S_WDATA, S_WACK,
		S_RDATA, S_RACK, S_IGNORE} twcrp_state_t;

	typedef struct packed {
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic [2:0] stat_sync_a;
		logic [2:0] stat_sync_b;
		logic [3:0] sel_sync;
		logic [TWCRP_FILTER_LEN-1:0] scl_hist;
		logic [TWCRP_FILTER_LEN-1:0] sda_hist;
		logic scl_f;
		logic sda_f;
		twcrp_state_t st;
		logic [7:0] shift;
		logic [3:0] bits;
		logic rw;
		logic [7:0] ptr;
		logic sda_oen;
		logic [4:0] slicer;
		logic [7:0] hold_before;
		logic [7:0] hold_after;
		logic [7:0] test_a;
		logic [7:0] test_b;
		logic [7:0] test_c;
		logic [2:0] fmt;
	} twcrp_slave_state_t;

	twcrp_slave_state_t state_ff;
	twcrp_slave_state_t nxt_state;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [7:0] rd_byte;
	logic [7:0] status_byte;

	////////////////////////////////////////////////////////////////////////////
	// Filtered lines change only when the history agrees, so spikes shorter than
	// the filter length never reach the protocol logic.
	assign scl_rise = ~state_ff.scl_f & (&state_ff.scl_hist);
	assign scl_fall = state_ff.scl_f & ~(|state_ff.scl_hist);
	assign start_seen = state_ff.scl_f & (&state_ff.scl_hist) & state_ff.sda_f
		& ~(|state_ff.sda_hist);
	assign stop_seen = state_ff.scl_f & (&state_ff.scl_hist) & ~state_ff.sda_f
		& (&state_ff.sda_hist);

	// Synchronised pins sit in bit order seven, six, five of the status byte
	assign status_byte = {state_ff.stat_sync_b, 5'h00};

	always_comb begin
		unique case (state_ff.ptr)
			TWCRP_REG_SYNC_POL: rd_byte = status_byte;
			TWCRP_REG_SLICER: rd_byte = {state_ff.slicer, 3'h0};
			TWCRP_REG_HOLD_BEFORE: rd_byte = state_ff.hold_before;
			TWCRP_REG_HOLD_AFTER: rd_byte = state_ff.hold_after;
			TWCRP_REG_TEST_A: rd_byte = state_ff.test_a;
			TWCRP_REG_TEST_B: rd_byte = state_ff.test_b;
			TWCRP_REG_TEST_C: rd_byte = state_ff.test_c;
			TWCRP_REG_FORMAT: rd_byte = {5'h00, state_ff.fmt};
			default: rd_byte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_state = state_ff;
		nxt_state.scl_sync = {state_ff.scl_sync[0], link.scl};
		nxt_state.sda_sync = {state_ff.sda_sync[0], link.sda};
		nxt_state.stat_sync_a = {i_hsync_pol, i_vsync_pol, i_hold_pol};
		nxt_state.stat_sync_b = state_ff.stat_sync_a;
		nxt_state.sel_sync = {state_ff.sel_sync[1:0], i_bus_addr_select_pins};
		nxt_state.scl_hist = {state_ff.scl_hist[TWCRP_FILTER_LEN-2:0], state_ff.scl_sync[1]};
		nxt_state.sda_hist = {state_ff.sda_hist[TWCRP_FILTER_LEN-2:0], state_ff.sda_sync[1]};
		if (&state_ff.scl_hist) nxt_state.scl_f = 1'b1;
		else if (~(|state_ff.scl_hist)) nxt_state.scl_f = 1'b0;
		if (&state_ff.sda_hist) nxt_state.sda_f = 1'b1;
		else if (~(|state_ff.sda_hist)) nxt_state.sda_f = 1'b0;

		if (start_seen) begin
			nxt_state.st = S_ADDR;
			nxt_state.bits = 4'h0;
			nxt_state.sda_oen = 1'b1;
		end else if (stop_seen) begin
			nxt_state.st = S_IDLE;
			nxt_state.sda_oen = 1'b1;
		end else if (scl_rise) begin
			unique case (state_ff.st)
				S_ADDR, S_PTR, S_WDATA: begin
					nxt_state.shift = {state_ff.shift[6:0], state_ff.sda_f};
					nxt_state.bits = state_ff.bits + 4'h1;
				end
				S_RACK: begin
					if (state_ff.sda_f) begin
						nxt_state.st = S_IGNORE;
					end else begin
						nxt_state.st = S_RDATA;
						nxt_state.bits = 4'h0;
					end
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			unique case (state_ff.st)
				S_ADDR: if (state_ff.bits == 4'h8) begin
					nxt_state.rw = state_ff.shift[0];
					if (state_ff.shift[7:1] == {TWCRP_ADDR_FIXED, state_ff.sel_sync[3:2]}) begin
						nxt_state.st = S_ADDR_ACK;
						nxt_state.sda_oen = 1'b0;
					end else begin
						nxt_state.st = S_IGNORE;
					end
				end
				S_ADDR_ACK: begin
					nxt_state.bits = 4'h0;
					if (state_ff.rw) begin
						nxt_state.st = S_RDATA;
						nxt_state.sda_oen = rd_byte[7];
						nxt_state.shift = {rd_byte[6:0], 1'b1};
						nxt_state.bits = 4'h1;
					end else begin
						nxt_state.st = S_PTR;
						nxt_state.sda_oen = 1'b1;
					end
				end
				S_PTR: if (state_ff.bits == 4'h8) begin
					if (state_ff.shift <= TWCRP_REG_TOP) begin
						nxt_state.ptr = state_ff.shift;
						nxt_state.st = S_PTR_ACK;
						nxt_state.sda_oen = 1'b0;
					end else begin
						nxt_state.st = S_IGNORE;
					end
				end
				S_WDATA: if (state_ff.bits == 4'h8) begin
					nxt_state.st = S_WACK;
					nxt_state.sda_oen = 1'b0;
					unique case (state_ff.ptr)
						TWCRP_REG_SLICER:
							nxt_state.slicer = state_ff.shift[7:TWCRP_SLICER_LSB];
						TWCRP_REG_HOLD_BEFORE: nxt_state.hold_before = state_ff.shift;
						TWCRP_REG_HOLD_AFTER: nxt_state.hold_after = state_ff.shift;
						TWCRP_REG_TEST_A: nxt_state.test_a = state_ff.shift;
						TWCRP_REG_TEST_B: nxt_state.test_b = state_ff.shift;
						TWCRP_REG_TEST_C: nxt_state.test_c = state_ff.shift;
						TWCRP_REG_FORMAT: nxt_state.fmt = state_ff.shift[2:0];
						default: begin
						end
					endcase
					if (state_ff.ptr < TWCRP_REG_TOP) nxt_state.ptr = state_ff.ptr + 8'h01;
				end
				S_PTR_ACK, S_WACK: begin
					nxt_state.st = S_WDATA;
					nxt_state.sda_oen = 1'b1;
					nxt_state.bits = 4'h0;
				end
				S_RDATA: begin
					if (state_ff.bits == 4'h8) begin
						nxt_state.st = S_RACK;
						nxt_state.sda_oen = 1'b1;
						if (state_ff.ptr < TWCRP_REG_TOP) nxt_state.ptr = state_ff.ptr + 8'h01;
					end else begin
						nxt_state.sda_oen = state_ff.shift[7];
						nxt_state.shift = {state_ff.shift[6:0], 1'b1};
						nxt_state.bits = state_ff.bits + 4'h1;
					end
				end
				S_RACK: begin
				end
				default: nxt_state.sda_oen = 1'b1;
			endcase
			if (state_ff.st == S_RDATA && state_ff.bits == 4'h8) nxt_state.shift = 8'hFF;
		end
		// Reload the byte on the acknowledged falling edge of a read
		if (!start_seen && !stop_seen && scl_fall && state_ff.st == S_RDATA
			&& state_ff.bits == 4'h0) begin
			nxt_state.sda_oen = rd_byte[7];
			nxt_state.shift = {rd_byte[6:0], 1'b1};
			nxt_state.bits = 4'h1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			state_ff <= '{scl_sync: 2'h3, sda_sync: 2'h3, stat_sync_a: 3'h0, stat_sync_b: 3'h0,
				sel_sync: 4'h0, scl_hist: '1, sda_hist: '1, scl_f: 1'b1, sda_f: 1'b1,
				st: S_IDLE, shift: 8'h00, bits: 4'h0, rw: 1'b0, ptr: 8'h00, sda_oen: 1'b1,
				slicer: TWCRP_SLICER_RESET, hold_before: TWCRP_HOLD_RESET,
				hold_after: TWCRP_HOLD_RESET, test_a: TWCRP_TEST_A_RESET,
				test_b: TWCRP_TEST_B_RESET, test_c: TWCRP_TEST_C_RESET,
				fmt: TWCRP_FORMAT_RESET[2:0]};
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Read-data entry from RACK sets bits to zero so the reload above fires
	assign link.s_sda_oen = state_ff.sda_oen;
	assign o_slicer_code = state_ff.slicer;
	assign o_hold_before = state_ff.hold_before;
	assign o_hold_after = state_ff.hold_after;
	assign o_test_a = state_ff.test_a;
	assign o_test_b = state_ff.test_b;
	assign o_test_c = state_ff.test_c;
	assign o_full_444 = state_ff.fmt[TWCRP_FMT_444_BIT];
	assign o_sample_mode = state_ff.fmt[TWCRP_FMT_SAMPLE_BIT];
	assign o_chroma_pair_red_first = state_ff.fmt[TWCRP_FMT_RED_FIRST_BIT];
endmodule

/* twcrp_master.sv */
// Purpose: Two-wire master that writes or reads the slave's control registers
// Assumes: Single command at a time, no arbitration with other masters
// Notes: Link clock made by a divider, quarter-period enable pulses
module twcrp_master (
	input wire logic i_clock,
	input wire logic i_rstn,
	twcrp_link_if.master link,
	input wire logic i_cmd_valid,
	input wire twcrp_pkg::twcrp_op_t i_cmd_op,
	input wire logic [6:0] i_cmd_addr,
	input wire logic [7:0] i_cmd_ptr,
	input wire logic [7:0] i_cmd_wdata,
	output logic o_cmd_ready,
	output logic o_done,
	output logic o_nack,
	output logic [7:0] o_rdata
);
	import twcrp_pkg::*;

	typedef enum {M_IDLE, M_START, M_BYTE, M_ACK, M_RESTART, M_STOP} twcrp_mstate_t;

	typedef struct packed {
		logic [1:0] sda_sync;
		logic [$clog2(TWCRP_QUARTER_CYC+1)-1:0] div;
		logic [1:0] phase;
		twcrp_mstate_t st;
		twcrp_op_t op;
		logic [1:0] idx;
		logic [7:0] shift;
		logic [3:0] bits;
		logic rx;
		logic scl_oen;
		logic sda_oen;
		logic nack;
		logic done;
		logic [7:0] rdata;
	} twcrp_master_state_t;

	twcrp_master_state_t state_ff;
	twcrp_master_state_t nxt_state;
	logic tick;

	////////////////////////////////////////////////////////////////////////////
	assign tick = (state_ff.div == '0);

	always_comb begin
		nxt_state = state_ff;
		nxt_state.sda_sync = {state_ff.sda_sync[0], link.sda};
		nxt_state.done = 1'b0;
		nxt_state.div = tick ? ($bits(state_ff.div))'(TWCRP_QUARTER_CYC - 1) : state_ff.div - 1'b1;
		if (state_ff.st == M_IDLE) begin
			if (i_cmd_valid) begin
				nxt_state.st = M_START;
				nxt_state.op = i_cmd_op;
				nxt_state.phase = 2'h0;
				nxt_state.idx = 2'h0;
				nxt_state.nack = 1'b0;
			end
		end else if (tick) begin
			nxt_state.phase = state_ff.phase + 2'h1;
			unique case (state_ff.st)
				M_START, M_RESTART: unique case (state_ff.phase)
					2'h0: nxt_state.sda_oen = 1'b1;
					2'h1: nxt_state.scl_oen = 1'b1;
					2'h2: nxt_state.sda_oen = 1'b0;
					default: begin
						nxt_state.scl_oen = 1'b0;
						nxt_state.st = M_BYTE;
						nxt_state.bits = 4'h0;
						nxt_state.rx = 1'b0;
						nxt_state.shift = {i_cmd_addr, state_ff.st == M_RESTART};
					end
				endcase
				M_BYTE: unique case (state_ff.phase)
					2'h0: nxt_state.sda_oen = state_ff.rx | state_ff.shift[7];
					2'h1: nxt_state.scl_oen = 1'b1;
					2'h2: nxt_state.shift = {state_ff.shift[6:0], state_ff.sda_sync[1]};
					default: begin
						nxt_state.scl_oen = 1'b0;
						nxt_state.bits = state_ff.bits + 4'h1;
						if (state_ff.bits == 4'h7) nxt_state.st = M_ACK;
					end
				endcase
				M_ACK: unique case (state_ff.phase)
					// Only one byte is read, so the master never acknowledges
					2'h0: nxt_state.sda_oen = 1'b1;
					2'h1: nxt_state.scl_oen = 1'b1;
					2'h2: if (!state_ff.rx && state_ff.sda_sync[1]) nxt_state.nack = 1'b1;
					default: begin
						nxt_state.scl_oen = 1'b0;
						nxt_state.idx = state_ff.idx + 2'h1;
						nxt_state.bits = 4'h0;
						if (state_ff.nack || state_ff.rx || (state_ff.idx == 2'h1
							&& state_ff.op == TWCRP_OP_SETPTR) || (state_ff.idx == 2'h2
							&& state_ff.op != TWCRP_OP_READ)) begin
							nxt_state.st = M_STOP;
							if (state_ff.rx) nxt_state.rdata = state_ff.shift;
						end else if (state_ff.idx == 2'h1 && state_ff.op == TWCRP_OP_READ) begin
							nxt_state.st = M_RESTART;
						end else if (state_ff.idx == 2'h2 && state_ff.shift[0]) begin
							nxt_state.st = M_BYTE;
							nxt_state.rx = 1'b1;
						end else begin
							nxt_state.st = M_BYTE;
							nxt_state.shift = (state_ff.idx == 2'h0) ? i_cmd_ptr : i_cmd_wdata;
						end
					end
				endcase
				M_STOP: unique case (state_ff.phase)
					2'h0: nxt_state.sda_oen = 1'b0;
					2'h1: nxt_state.scl_oen = 1'b1;
					2'h2: nxt_state.sda_oen = 1'b1;
					default: begin
						nxt_state.st = M_IDLE;
						nxt_state.done = 1'b1;
					end
				endcase
				default: nxt_state.st = M_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			state_ff <= '{sda_sync: 2'h3, div: '0, phase: 2'h0, st: M_IDLE, op: TWCRP_OP_WRITE,
				idx: 2'h0, shift: 8'h00, bits: 4'h0, rx: 1'b0, scl_oen: 1'b1, sda_oen: 1'b1,
				nack: 1'b0, done: 1'b0, rdata: 8'h00};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign link.m_scl_oen = state_ff.scl_oen;
	assign link.m_sda_oen = state_ff.sda_oen;
	assign o_cmd_ready = (state_ff.st == M_IDLE);
	assign o_done = state_ff.done;
	assign o_nack = state_ff.nack;
	assign o_rdata = state_ff.rdata;
endmodule

/* twcrp_link_properties.sv */
// Purpose: Link checks for the two-wire control register port
// Assumes: Sees the wire levels and enables of the link between both ends
// Notes: Pulse count restarts at every start or stop on the wire
module twcrp_link_properties
	import twcrp_pkg::*;
#(
	parameter logic [1:0] SEL = 2'h0
) (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic m_scl_oen,
	input wire logic m_sda_oen,
	input wire logic s_sda_oen,
	input wire logic scl,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;
	logic scl_ff, sda_ff, hi, ok, rise;
	logic [4:0] cnt_ff, low_ff;
	logic [15:0] high_ff;
	logic [7:0] ash_ff, psh_ff;
	assign hi = scl && scl_ff;
	assign rise = scl && !scl_ff;
	assign ok = ash_ff[7:1] == {TWCRP_ADDR_FIXED, SEL};
	////////////////////////////////////////
	// Address and pointer bytes captured at clock rises
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			{scl_ff, sda_ff, cnt_ff, low_ff, high_ff, ash_ff, psh_ff} <= '1;
		end else begin
			scl_ff <= scl;
			sda_ff <= sda;
			high_ff <= !scl ? 16'h0000 : (&high_ff) ? high_ff : high_ff + 16'h0001;
			low_ff <= scl ? 5'h00 : (&low_ff) ? low_ff : low_ff + 5'h01;
			if (hi && sda != sda_ff)
				cnt_ff <= 5'h00;
			else if (rise && !(&cnt_ff))
				cnt_ff <= cnt_ff + 5'h01;
			if (rise && cnt_ff < 5'h08)
				ash_ff <= {ash_ff[6:0], sda};
			if (rise && cnt_ff > 5'h08 && cnt_ff < 5'h11)
				psh_ff <= {psh_ff[6:0], sda};
		end
	end
	////////////////////////////////////////
	default clocking dcb @(posedge i_clock);
	endclocking
	default disable iff (!i_rstn);
	property p_addr_ack;
		hi && cnt_ff == 5'h09 && ok |-> !s_sda_oen;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
	property p_addr_nack;
		hi && cnt_ff == 5'h09 && !ok |-> s_sda_oen;
	endproperty
	a_addr_nack: assert property (p_addr_nack) else $error("foreign address acked");
	property p_ptr_ack;
		hi && cnt_ff == 5'h12 && ok && !ash_ff[0] && psh_ff <= TWCRP_REG_TOP |-> !s_sda_oen;
	endproperty
	a_ptr_ack: assert property (p_ptr_ack) else $error("pointer not acknowledged");
	property p_ptr_nack;
		hi && cnt_ff == 5'h12 && ok && !ash_ff[0] && psh_ff > TWCRP_REG_TOP |-> s_sda_oen;
	endproperty
	a_ptr_nack: assert property (p_ptr_nack) else $error("pointer past top acked");
	property p_read_release;
		hi && cnt_ff == 5'h12 && ok && ash_ff[0] |-> s_sda_oen [*4];
	endproperty
	a_read_release: assert property (p_read_release) else $error("data held in ack slot");
	// Slave reacts through its filter, so a change well after the fall is a fault
	property p_change_low;
		$changed(s_sda_oen) |-> !scl && low_ff <= 5'h10;
	endproperty
	a_change_low: assert property (p_change_low) else $error("data moved off clock low");
	property p_start_master;
		hi && $fell(sda) |-> s_sda_oen && !m_sda_oen;
	endproperty
	a_start_master: assert property (p_start_master) else $error("start not from master");
	property p_idle_release;
		high_ff > 16'h03E8 |-> s_sda_oen [*2];
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("data held on idle bus");
	c_read: cover property (hi && cnt_ff == 5'h12 && ok && ash_ff[0]);
	c_ptr_nack: cover property (hi && cnt_ff == 5'h12 && ok && psh_ff > TWCRP_REG_TOP);
	c_addr_nack: cover property (hi && cnt_ff == 5'h09 && !ok);
endmodule

/* tb.sv */
// Purpose: Self-checking bench for the two-wire control register port
// Assumes: Design master on link a; bench drives link b bit by bit
// Notes: Design link runs slowly, so link a carries only four commands
module tb
	import twcrp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [1:0] SEL_A = 2'h2;
	logic i_clock = 1'b0;
	logic i_rstn = 1'b0;
	logic cmd_valid = 1'b0;
	logic bscl = 1'b1;
	logic bsda = 1'b1;
	logic hpol = 1'b0;
	logic vpol = 1'b0;
	logic hold_pol = 1'b0;
	logic [1:0] sel_b = 2'h0;
	twcrp_op_t cmd_op = TWCRP_OP_WRITE;
	logic [6:0] cmd_addr = 7'h00;
	logic [7:0] cmd_ptr = 8'h00;
	logic [7:0] cmd_wdata = 8'h00;
	logic cmd_ready, done, nack;
	logic [7:0] rdata_a;
	logic [47:0] oa, ob;
	logic [7:0] mr[2][32];
	int mp[2];
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	twcrp_link_if link_a();
	twcrp_link_if link_b();
	assign link_b.m_scl_oen = bscl;
	assign link_b.m_sda_oen = bsda;
	always #5 i_clock = ~i_clock;
	twcrp_slave u_twcrp_slave (.i_clock, .i_rstn, .link(link_a.slave), .i_bus_addr_select_pins(SEL_A),
		.i_hsync_pol(hpol), .i_vsync_pol(vpol), .i_hold_pol(hold_pol), .o_slicer_code(oa[47:43]),
		.o_hold_before(oa[42:35]), .o_hold_after(oa[34:27]), .o_test_a(oa[26:19]),
		.o_test_b(oa[18:11]), .o_test_c(oa[10:3]), .o_full_444(oa[2]), .o_sample_mode(oa[1]),
		.o_chroma_pair_red_first(oa[0]));
	twcrp_slave u_twcrp_slave_b (.i_clock, .i_rstn, .link(link_b.slave), .i_bus_addr_select_pins(sel_b),
		.i_hsync_pol(hpol), .i_vsync_pol(vpol), .i_hold_pol(hold_pol), .o_slicer_code(ob[47:43]),
		.o_hold_before(ob[42:35]), .o_hold_after(ob[34:27]), .o_test_a(ob[26:19]),
		.o_test_b(ob[18:11]), .o_test_c(ob[10:3]), .o_full_444(ob[2]), .o_sample_mode(ob[1]),
		.o_chroma_pair_red_first(ob[0]));
	twcrp_master u_twcrp_master (.i_clock, .i_rstn, .link(link_a.master), .i_cmd_valid(cmd_valid),
		.i_cmd_op(cmd_op), .i_cmd_addr(cmd_addr), .i_cmd_ptr(cmd_ptr), .i_cmd_wdata(cmd_wdata),
		.o_cmd_ready(cmd_ready), .o_done(done), .o_nack(nack), .o_rdata(rdata_a));
	twcrp_link_properties #(.SEL(SEL_A)) u_twcrp_link_properties (.i_clock, .i_rstn,
		.m_scl_oen(link_a.m_scl_oen), .m_sda_oen(link_a.m_sda_oen), .s_sda_oen(link_a.s_sda_oen),
		.scl(link_a.scl), .sda(link_a.sda));
	////////////////////////////////////////
	// Four slow commands on link a dominate the run time
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 130000) begin
			err_count++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [7:0] mrd(int s);
		logic [7:0] v;
		v = (mp[s] == 8'h15) ? {hpol, vpol, hold_pol, 5'h00} : mr[s][mp[s]];
		mp[s] = (mp[s] < 8'h1D) ? mp[s] + 1 : mp[s];
		return v;
	endfunction
	function automatic void mwr(int s, logic [7:0] d);
		if (mp[s] == 8'h16)
			mr[s][mp[s]] = d & 8'hF8;
		if (mp[s] > 8'h16 && mp[s] < 8'h1C)
			mr[s][mp[s]] = d;
		if (mp[s] == 8'h1C)
			mr[s][mp[s]] = d & 8'h07;
		mp[s] = (mp[s] < 8'h1D) ? mp[s] + 1 : mp[s];
	endfunction
	function automatic logic [47:0] eo(int s);
		return {mr[s][8'h16][7:3], mr[s][8'h17], mr[s][8'h18], mr[s][8'h19], mr[s][8'h1A],
			mr[s][8'h1B], mr[s][8'h1C][0], mr[s][8'h1C][1], mr[s][8'h1C][2]};
	endfunction
	task automatic mcmd(input twcrp_op_t op, input logic [7:0] p, input logic [6:0] a);
		@(negedge i_clock);
		cmd_op = op;
		cmd_ptr = p;
		cmd_addr = a;
		cmd_wdata = 8'($urandom);
		cmd_valid = 1'b1;
		@(negedge i_clock);
		while (done !== 1'b1) @(negedge i_clock);
		cmd_valid = 1'b0;
		chk("ready after done", cmd_ready, 1'b1);
	endtask
	////////////////////////////////////////
	// Link b: 160 ns bit, four quarters
	task automatic q();
		repeat (4) @(negedge i_clock);
	endtask
	task automatic bstart();
		bsda = 1'b1;
		q();
		q();
		bscl = 1'b1;
		q();
		bsda = 1'b0;
		q();
		bscl = 1'b0;
		q();
	endtask
	task automatic bstop();
		bsda = 1'b0;
		q();
		bscl = 1'b1;
		q();
		bsda = 1'b1;
		q();
		q();
	endtask
	task automatic bbit(input logic b, output logic r);
		bsda = b;
		q();
		bscl = 1'b1;
		q();
		r = link_b.sda;
		q();
		bscl = 1'b0;
		q();
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bbit(d[i], r);
		bbit(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bbit(1'b1, d[i]);
		bbit(!more, r);
	endtask
	task automatic bread(input logic [7:0] p, input int n);
		logic a;
		logic [7:0] v;
		bstart();
		wbyte({TWCRP_ADDR_FIXED, sel_b, 1'b0}, a);
		wbyte(p, a);
		chk("pointer ack", a, 1'b1);
		mp[1] = p;
		bstart();
		wbyte({TWCRP_ADDR_FIXED, sel_b, 1'b1}, a);
		for (int i = 0; i < n; i++) begin
			rbyte(i < n - 1, v);
			chk("read back", v, mrd(1));
		end
		q();
		q();
		chk("line after master nack", link_b.sda, 1'b1);
		bstop();
	endtask
	////////////////////////////////////////
	initial begin
		logic ack;
		logic [7:0] d;
		void'($urandom(64172));
		{hpol, vpol, hold_pol} = 3'($urandom);
		foreach (mr[s, i]) mr[s][i] = 8'h00;
		for (int s = 0; s < 2; s++) begin
			mr[s][8'h16] = {TWCRP_SLICER_RESET, 3'h0};
			mr[s][8'h1C] = 8'h01;
		end
		repeat (12) @(negedge i_clock);
		i_rstn = 1'b1;
		@(negedge i_clock);
		chk("outputs a", oa, eo(0));
		chk("outputs b", ob, eo(1));
		$display("test reset done");
		mcmd(TWCRP_OP_WRITE, 8'h17, {TWCRP_ADDR_FIXED, SEL_A});
		mp[0] = 8'h17;
		mwr(0, cmd_wdata);
		chk("write nack", nack, 1'b0);
		chk("outputs a", oa, eo(0));
		mcmd(TWCRP_OP_READ, 8'h17, {TWCRP_ADDR_FIXED, SEL_A});
		mp[0] = 8'h17;
		chk("read data", rdata_a, mrd(0));
		mcmd(TWCRP_OP_SETPTR, 8'h1E, {TWCRP_ADDR_FIXED, SEL_A});
		chk("pointer nack", nack, 1'b1);
		mcmd(TWCRP_OP_WRITE, 8'h17, {TWCRP_ADDR_FIXED, ~SEL_A});
		chk("foreign nack", nack, 1'b1);
		chk("outputs a", oa, eo(0));
		$display("test master end done");
		for (int k = 0; k < 16; k++) begin
			sel_b = 2'(k >> 2);
			bstart();
			wbyte({TWCRP_ADDR_FIXED, 2'(k), 1'b0}, ack);
			bstop();
			chk("address match", ack, (k >> 2) == (k & 3));
		end
		bread(8'h15, 11);
		bstart();
		wbyte({TWCRP_ADDR_FIXED, sel_b, 1'b0}, ack);
		wbyte(8'h15, ack);
		mp[1] = 8'h15;
		for (int i = 0; i < 10; i++) begin
			d = 8'($urandom);
			// Host keeps test settings fixed; 0x1A needs 0x41 to run properly
			if (i == 4 || i == 6)
				d = 8'h00;
			if (i == 5)
				d = 8'h41;
			if (i == 7)
				d = d & 8'h05;
			wbyte(d, ack);
			mwr(1, d);
			chk("data ack", ack, 1'b1);
		end
		bstop();
		chk("outputs b", ob, eo(1));
		{hpol, vpol, hold_pol} = 3'($urandom);
		bread(8'h15, 11);
		bstart();
		wbyte({TWCRP_ADDR_FIXED, sel_b, 1'b0}, ack);
		wbyte(8'h1E, ack);
		chk("pointer 1E", ack, 1'b0);
		q();
		chk("line after refusal", link_b.sda, 1'b1);
		bstop();
		$display("test serial end done");
		summarize();
	end
endmodule
